// ==== ioad_pkg.sv ====
package ioad_pkg;

  // Widths of the address path
  localparam int ADDR_W = 12;
  localparam int FILE_W = 8;
  localparam int BANK_W = 4;
  localparam int LIT_W = 6;
  localparam int PC_W = 21;
  localparam int INSTR_W = 16;
  localparam int NUM_PTR = 3;

  // Opcode patterns
  localparam logic [7:0] OP_SUBTRACT_FROM_POINTER_HI = 8'he9;
  localparam logic [1:0] SEL_RETURN = 2'h3;
  localparam logic [1:0] SEL_PTR_TWO = 2'h2;

  // Field positions in the instruction word
  localparam int OPHI_MSB = 15;
  localparam int OPHI_LSB = 8;
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 6;
  localparam int LIT_MSB = 5;
  localparam int FILE_MSB = 7;
  localparam int ACCESS_BIT = 8;
  localparam int DEST_BIT = 9;

  // Access-bank split and data space limits
  localparam logic [FILE_W-1:0] INDEX_LIMIT = 8'h5f;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_PAGE = 4'hf;
  localparam logic [BANK_W-1:0] ACCESS_LOW_PAGE = 4'h0;

  // Reset values
  localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

  typedef enum logic [0:0] {
    IOAD_ST_EXEC = 1'b0,
    IOAD_ST_NOP = 1'b1
  } ioad_state_type;

  // Result of decoding one file-operand instruction
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic valid;
    logic indexed;
    logic dest_file;
  } ioad_access_type;

  // Result of a pointer subtraction
  typedef struct packed {
    logic [PC_W-1:0] pc_value;
    logic pc_load;
    logic nop_next;
  } ioad_flow_type;

  // Byte- and bit-oriented opcodes that carry the access bit
  function automatic logic ioad_has_access(
    input logic [INSTR_W-1:0] w
  );
    logic r;
    r = 1'b0;
    if (w[15:9] == 7'h01) begin
      r = 1'b1;
    end else if (w[15:10] == 6'h01) begin
      r = 1'b1;
    end else if (w[15:12] >= 4'h1 && w[15:12] <= 4'hb) begin
      r = 1'b1;
    end
    return r;
  endfunction

  // Opcodes whose bit 9 is the destination choice
  function automatic logic ioad_has_dest(input logic [INSTR_W-1:0] w);
    logic r;
    r = 1'b0;
    if (w[15:10] == 6'h01) begin
      r = 1'b1;
    end else if (w[15:12] >= 4'h1 && w[15:12] <= 4'h5) begin
      r = 1'b1;
    end
    return r;
  endfunction

endpackage

// ==== ioad_ptr_reg.sv ====
`timescale 1ns/1ns
module ioad_ptr_reg
  import ioad_pkg::*;
#(
  parameter int W = ADDR_W,
  parameter int LW = LIT_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Update requests
  input wire logic i_load,
  input wire logic [W-1:0] i_load_value,
  input wire logic i_sub,
  input wire logic [LW-1:0] i_lit,
  // Current value
  output logic [W-1:0] o_value
);

  logic [W-1:0] value;
  logic [W-1:0] next_value;

  initial begin
    if (LW >= W || W < 1) begin
      $error("ioad_ptr_reg: literal must be narrower than pointer");
    end
  end

  // Subtraction wraps within the data space
  always_comb begin
    next_value = value;
    if (i_sub) begin
      next_value = value - W'(i_lit);
    end else if (i_load) begin
      next_value = i_load_value;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      value <= W'(PTR_RESET);
    end else begin
      value <= next_value;
    end
  end

  assign o_value = value;

endmodule // ioad_ptr_reg

// ==== ioad_decode.sv ====
`timescale 1ns/1ns
// Summary of operation
// RL1: Return-subtract takes 6-bit literal 0..63 off pointer two, writes back.
// RL2: After pointer update, return-subtract loads program counter from stack top.
// RL3: Return-subtract is one word, two cycles; second cycle is a no-op.
// RL4: Pattern 1110 1001 11kk kkkk, select 11, acts only on pointer two.
// RL5: Extension off: access bit 0 uses access bank, 1 uses selected bank.
// RL6: Extension on, access bit 0, operand up to 5Fh: pointer two plus offset.
// RL7: Remap applies to every byte and bit instruction carrying the access bit.
// RL8: Extension enable alone turns on indexed offset mode; no other control.
// RL9: Pointer two zero makes indexed addresses equal the plain access addresses.
// RL10: Destination bit keeps its meaning: working register or file register.
// RL11: Extension on, access bit 0, operand above 5Fh: plain access bank.
// RL12: Pointer subtract takes 6-bit literal off pointer zero, one or two.
// RL13: Pointer-based address wraps within 12-bit, 4096-byte data space.
// RL14: Extended set and indexed mode are on when enable bit is 1.
module ioad_decode
  import ioad_pkg::*;
#(
  parameter int PCW = PC_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Configuration
  input wire logic i_extended_set_enable,
  // Instruction stream
  input wire logic i_instr_valid,
  input wire logic [INSTR_W-1:0] i_instr,
  output logic o_instr_ready,
  // Core state feeding the address path and program flow
  input wire logic [BANK_W-1:0] i_bank_select_register,
  input wire logic [PCW-1:0] i_top_of_return_stack,
  // Pointer load from other instructions
  input wire logic i_ptr_load,
  input wire logic [1:0] i_ptr_load_sel,
  input wire logic [ADDR_W-1:0] i_ptr_load_value,
  // Data memory address path
  output logic [ADDR_W-1:0] o_data_addr,
  output logic o_data_addr_valid,
  output logic o_indexed,
  output logic o_dest_file,
  // Program flow
  output logic o_pc_load,
  output logic [PCW-1:0] o_pc_value,
  output logic o_nop_cycle,
  // Status
  output logic o_extended_active,
  output logic [ADDR_W-1:0] o_ptr_zero,
  output logic [ADDR_W-1:0] o_ptr_one,
  output logic [ADDR_W-1:0] o_ptr_two
);

  initial begin
    if (PCW < 1 || PCW > 32) begin
      $error("ioad_decode: program counter width out of range");
    end
  end

  ioad_state_type state;
  ioad_state_type next_state;

  logic ext_meta;
  logic ext_sync;
  logic accept;
  logic is_subtract_from_pointer;
  logic is_return;
  logic [1:0] sel;
  logic [LIT_W-1:0] lit;
  logic [FILE_W-1:0] file_op;
  logic access_bit;
  logic [ADDR_W-1:0] ptr_val [NUM_PTR];
  logic [NUM_PTR-1:0] ptr_sub;
  logic [NUM_PTR-1:0] ptr_load;
  ioad_access_type next_access;
  ioad_flow_type next_flow;
  ioad_access_type access;
  ioad_flow_type flow;

  // Enable bit comes from outside the core clock; two flops first
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end else begin
      ext_meta <= i_extended_set_enable;
      ext_sync <= ext_meta;
    end
  end

  // One bit turns on both the new opcodes and indexed mode
  assign o_extended_active = ext_sync; // [RL8] [RL14]

  // Second cycle of a return blocks the next word
  assign o_instr_ready = (state == IOAD_ST_EXEC); // [RL3]
  assign accept = i_instr_valid && o_instr_ready;

  // Field extraction
  assign sel = i_instr[SEL_MSB:SEL_LSB];
  assign lit = i_instr[LIT_MSB:0];
  assign file_op = i_instr[FILE_MSB:0];
  assign access_bit = i_instr[ACCESS_BIT];

  // Pointer-subtract opcodes exist only with the extension on
  assign is_subtract_from_pointer =
    ext_sync && (i_instr[OPHI_MSB:OPHI_LSB] == OP_SUBTRACT_FROM_POINTER_HI); // [RL4]
  assign is_return = is_subtract_from_pointer && (sel == SEL_RETURN); // [RL4]

  // Select 11 is redirected to pointer two
  always_comb begin
    ptr_sub = '0;
    ptr_load = '0;
    for (int i = 0; i < NUM_PTR; i++) begin
      if (accept && is_subtract_from_pointer) begin
        if (sel == 2'(i)) begin
          ptr_sub[i] = 1'b1; // [RL12]
        end else if (is_return && sel == SEL_RETURN &&
                     2'(i) == SEL_PTR_TWO) begin
          ptr_sub[i] = 1'b1; // [RL1] [RL4]
        end
      end
      if (i_ptr_load && i_ptr_load_sel == 2'(i)) begin
        ptr_load[i] = 1'b1;
      end
    end
  end

  // Subtraction has priority over an external load in the same cycle
  ioad_ptr_reg #(
    .W(ADDR_W),
    .LW(LIT_W)
  ) u_ptr_zero (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(ptr_load[0]),
    .i_load_value(i_ptr_load_value),
    .i_sub(ptr_sub[0]),
    .i_lit(lit),
    .o_value(ptr_val[0])
  );

  ioad_ptr_reg #(
    .W(ADDR_W),
    .LW(LIT_W)
  ) u_ptr_one (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(ptr_load[1]),
    .i_load_value(i_ptr_load_value),
    .i_sub(ptr_sub[1]),
    .i_lit(lit),
    .o_value(ptr_val[1])
  );

  ioad_ptr_reg #(
    .W(ADDR_W),
    .LW(LIT_W)
  ) u_ptr_two (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(ptr_load[2]),
    .i_load_value(i_ptr_load_value),
    .i_sub(ptr_sub[2]), // [RL1]
    .i_lit(lit),
    .o_value(ptr_val[2])
  );

  assign o_ptr_zero = ptr_val[0];
  assign o_ptr_one = ptr_val[1];
  assign o_ptr_two = ptr_val[2];

  // Effective address of a file operand
  always_comb begin
    next_access = '0;
    if (accept && ioad_has_access(i_instr)) begin // [RL7]
      next_access.valid = 1'b1;
      next_access.dest_file = 1'b0;
      if (ioad_has_dest(i_instr)) begin
        next_access.dest_file = i_instr[DEST_BIT]; // [RL10]
      end
      if (access_bit) begin
        next_access.addr = {i_bank_select_register, file_op}; // [RL5]
      end else if (ext_sync && file_op <= INDEX_LIMIT) begin
        // Sum wraps at the top of the data space; pointer two at zero gives identity
        next_access.addr =
          ptr_val[2] + ADDR_W'(file_op); // [RL6] [RL9] [RL13]
        next_access.indexed = 1'b1; // [RL6]
      end else if (file_op <= INDEX_LIMIT) begin
        next_access.addr = {ACCESS_LOW_PAGE, file_op}; // [RL5]
      end else begin
        // Upper access half never indexes
        next_access.addr = {ACCESS_HIGH_PAGE, file_op}; // [RL5] [RL11]
      end
    end
  end

  // Program flow for the return form
  always_comb begin
    next_flow = '0;
    if (accept && is_return) begin
      next_flow.pc_load = 1'b1; // [RL2]
      next_flow.pc_value = i_top_of_return_stack; // [RL2]
      next_flow.nop_next = 1'b1; // [RL3]
    end
  end

  // Two-cycle sequencing
  always_comb begin
    next_state = state;
    case (state)
      IOAD_ST_EXEC: begin
        if (next_flow.nop_next) begin
          next_state = IOAD_ST_NOP; // [RL3]
        end
      end
      IOAD_ST_NOP: begin
        next_state = IOAD_ST_EXEC; // [RL3]
      end
      default: begin
        next_state = IOAD_ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= IOAD_ST_EXEC;
    end else begin
      state <= next_state;
    end
  end

  // Address path registers; address holds between valid pulses
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      access <= '0;
    end else begin
      access.valid <= next_access.valid;
      if (next_access.valid) begin
        access.addr <= next_access.addr;
        access.indexed <= next_access.indexed;
        access.dest_file <= next_access.dest_file;
      end
    end
  end

  // Flow registers; the load pulses one cycle, pointer already updated
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flow <= '0;
      flow.pc_value <= PCW'(PC_RESET);
    end else begin
      flow.pc_load <= next_flow.pc_load; // [RL2]
      flow.nop_next <= next_flow.nop_next; // [RL3]
      if (next_flow.pc_load) begin
        flow.pc_value <= next_flow.pc_value;
      end
    end
  end

  assign o_data_addr = access.addr;
  assign o_data_addr_valid = access.valid;
  assign o_indexed = access.indexed;
  assign o_dest_file = access.dest_file;
  assign o_pc_load = flow.pc_load;
  assign o_pc_value = flow.pc_value;
  assign o_nop_cycle = flow.nop_next;

endmodule // ioad_decode

// ==== ioad_decode_asserts.sv ====
`timescale 1ns/1ns
module ioad_chk
  import ioad_pkg::*;
#(
  parameter int PCW = PC_W
) (
  // Watched ports
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_instr_valid,
  input wire logic [INSTR_W-1:0] i_instr,
  input wire logic [BANK_W-1:0] i_bank_select_register,
  input wire logic [PCW-1:0] i_top_of_return_stack,
  input wire logic i_ptr_load,
  input wire logic o_instr_ready,
  input wire logic [ADDR_W-1:0] o_data_addr,
  input wire logic o_indexed,
  input wire logic o_dest_file,
  input wire logic o_pc_load,
  input wire logic [PCW-1:0] o_pc_value,
  input wire logic o_nop_cycle,
  input wire logic o_extended_active,
  input wire logic [ADDR_W-1:0] o_ptr_zero,
  input wire logic [ADDR_W-1:0] o_ptr_two
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Subset of access-bit opcodes, enough for a tight check
  wire tk = i_instr_valid && o_instr_ready;
  wire acc = tk && i_instr[15:12] >= 4'h1 && i_instr[15:12] <= 4'hb;
  wire sub = tk && o_extended_active && i_instr[15:8] == OP_SUBTRACT_FROM_POINTER_HI;
  wire low = !i_instr[ACCESS_BIT] && i_instr[7:0] <= INDEX_LIMIT;
  chk_ret_pc_load: assert property (
    sub && i_instr[7:6] == SEL_RETURN |=>
    o_pc_load && o_nop_cycle && !o_instr_ready &&
    o_pc_value == $past(i_top_of_return_stack)) else $error("bad return");
  chk_ret_ptr_sub: assert property (
    sub && i_instr[7:6] == SEL_RETURN |=>
    o_ptr_two == $past(o_ptr_two) - 12'($past(i_instr[5:0])))
    else $error("bad pointer two");
  chk_sub_ptr_zero: assert property (sub && i_instr[7:6] == 2'h0 &&
    !i_ptr_load |=>
    o_ptr_zero == $past(o_ptr_zero) - 12'($past(i_instr[5:0])))
    else $error("bad pointer zero");
  chk_ready_low: assert property (!o_instr_ready |-> o_pc_load)
    else $error("ready low without return");
  chk_index_addr: assert property (
    acc && o_extended_active && low |=> o_indexed &&
    o_data_addr == $past(o_ptr_two) + 12'($past(i_instr[7:0])))
    else $error("bad indexed address");
  chk_plain_low: assert property (
    acc && !o_extended_active && low |=>
    !o_indexed && o_data_addr == {4'h0, $past(i_instr[7:0])})
    else $error("bad plain address");
  chk_bank_addr: assert property (
    acc && i_instr[ACCESS_BIT] |=> !o_indexed &&
    o_data_addr == {$past(i_bank_select_register), $past(i_instr[7:0])})
    else $error("bad bank address");
  chk_high_access: assert property (acc && !i_instr[ACCESS_BIT] &&
    i_instr[7:0] > INDEX_LIMIT |=> o_data_addr == {4'hf, $past(i_instr[7:0])})
    else $error("bad high access address");
  chk_dest_bit: assert property (acc && i_instr[15:12] <= 4'h5 |=>
    o_dest_file == $past(i_instr[DEST_BIT])) else $error("bad destination");
endmodule // ioad_chk

bind ioad_decode ioad_chk #(.PCW(PCW)) i_ioad_chk (.i_clk(i_clk),
  .i_rst(i_rst),
  .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_ptr_load(i_ptr_load),
  .i_bank_select_register(i_bank_select_register),
  .i_top_of_return_stack(i_top_of_return_stack), .o_indexed(o_indexed),
  .o_instr_ready(o_instr_ready), .o_data_addr(o_data_addr),
  .o_dest_file(o_dest_file), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
  .o_nop_cycle(o_nop_cycle), .o_extended_active(o_extended_active),
  .o_ptr_zero(o_ptr_zero), .o_ptr_two(o_ptr_two));

// ==== test_indexed_offset_address_decode.sv ====
`timescale 1ns/1ns
module test_indexed_offset_address_decode;
  import ioad_pkg::*;
  logic i_clk = 0, i_rst = 1, i_extended_set_enable = 1, i_instr_valid = 0;
  logic [15:0] i_instr = 0;
  logic [3:0] i_bank_select_register = 4'h5;
  logic [20:0] i_top_of_return_stack = 21'h012345;
  logic i_ptr_load = 0;
  logic [1:0] i_ptr_load_sel = 0;
  logic [11:0] i_ptr_load_value = 0, o_data_addr;
  logic [11:0] o_ptr_zero, o_ptr_one, o_ptr_two;
  logic o_instr_ready, o_data_addr_valid, o_indexed, o_dest_file, o_pc_load;
  logic o_nop_cycle, o_extended_active;
  logic [20:0] o_pc_value;
  int n_errors = 0, check_count = 0, cyc = 0;
  logic [11:0] pv [3];
  ioad_decode i_ioad_decode (.i_clk(i_clk), .i_rst(i_rst),
    .i_extended_set_enable(i_extended_set_enable), .i_instr(i_instr),
    .i_instr_valid(i_instr_valid), .o_instr_ready(o_instr_ready),
    .i_bank_select_register(i_bank_select_register),
    .i_top_of_return_stack(i_top_of_return_stack), .i_ptr_load(i_ptr_load),
    .i_ptr_load_sel(i_ptr_load_sel), .i_ptr_load_value(i_ptr_load_value),
    .o_data_addr(o_data_addr), .o_data_addr_valid(o_data_addr_valid),
    .o_indexed(o_indexed), .o_dest_file(o_dest_file), .o_pc_load(o_pc_load),
    .o_pc_value(o_pc_value), .o_nop_cycle(o_nop_cycle),
    .o_extended_active(o_extended_active), .o_ptr_zero(o_ptr_zero),
    .o_ptr_one(o_ptr_one), .o_ptr_two(o_ptr_two));
  always #5 i_clk = ~i_clk;
  // Cut a hang short well past the expected run length
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [20:0] e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ld(input logic [1:0] s, input logic [11:0] v);
    @(posedge i_clk) #1 i_ptr_load = 1;
    i_ptr_load_sel = s;
    i_ptr_load_value = v;
    @(posedge i_clk) #1 i_ptr_load = 0;
  endtask
  // One file-operand word, judged the cycle after it is taken
  task automatic op(input logic [15:0] w, input logic [11:0] a,
                    input logic x, d);
    @(posedge i_clk) #1 i_instr_valid = 1;
    i_instr = w;
    @(posedge i_clk) #1 i_instr_valid = 0;
    chk("valid", 1, o_data_addr_valid);
    chk("addr", a, o_data_addr);
    chk("indexed", x, o_indexed);
    chk("dest", d, o_dest_file);
  endtask
  task automatic t_enable();
    repeat (3) @(posedge i_clk);
    #1 chk("active", 1, o_extended_active);
  endtask
  task automatic t_index();
    ld(2, 12'ha00);
    op(16'h2601, 12'ha01, 1, 1);
    op(16'h8e0a, 12'ha0a, 1, 0);
    op(16'h2660, 12'hf60, 0, 1);
    op(16'h2705, 12'h505, 0, 1);
    ld(2, 12'hfff);
    op(16'h2402, 12'h001, 1, 0);
    ld(2, 12'h000);
    op(16'h6a2c, 12'h02c, 1, 0);
  endtask
  task automatic t_ret();
    ld(2, 12'h3ff);
    @(posedge i_clk) #1 i_instr_valid = 1;
    i_instr = 16'he9e3;
    @(posedge i_clk) #1 i_instr = 16'h2601;
    chk("ptr2", 12'h3dc, o_ptr_two);
    chk("pc_load", 1, o_pc_load);
    chk("pc_value", 21'h012345, o_pc_value);
    chk("nop", 1, o_nop_cycle);
    chk("ready", 0, o_instr_ready);
    @(posedge i_clk) #1 i_instr_valid = 0;
    chk("refused", 0, o_data_addr_valid);
    chk("ready", 1, o_instr_ready);
  endtask
  task automatic t_sub();
    for (int s = 0; s < 3; s++) begin
      ld(0, 12'h100);
      ld(1, 12'h100);
      ld(2, 12'h100);
      @(posedge i_clk) #1 i_instr_valid = 1;
      i_instr = 16'he905 | 16'(s << 6);
      @(posedge i_clk) #1 i_instr_valid = 0;
      chk("valid", 0, o_data_addr_valid);
      chk("pc_load", 0, o_pc_load);
      chk("ptr0", s == 0 ? 12'h0fb : 12'h100, o_ptr_zero);
      chk("ptr1", s == 1 ? 12'h0fb : 12'h100, o_ptr_one);
      chk("ptr2", s == 2 ? 12'h0fb : 12'h100, o_ptr_two);
    end
  endtask
  task automatic t_off();
    #0 i_extended_set_enable = 0;
    repeat (4) @(posedge i_clk);
    #1 chk("active", 0, o_extended_active);
    op(16'h2601, 12'h001, 0, 1);
    @(posedge i_clk) #1 i_instr_valid = 1;
    i_instr = 16'he9e3;
    @(posedge i_clk) #1 i_instr_valid = 0;
    chk("pc_load", 0, o_pc_load);
    chk("ptr2", 12'h0fb, o_ptr_two);
  endtask
  task automatic close_out();
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    #1 i_rst = 0;
    t_enable();
    t_index();
    t_ret();
    t_sub();
    t_off();
    close_out();
  end
endmodule // test_indexed_offset_address_decode
